// [core/dsb_pkg.sv]
// Purpose: Shared constants and types for the DMA system bus interface.
// Assumes: One clock (pclk), APB register access, 16-bit muxed bus.
// Notes: Register word index times four gives the APB byte address.
//
// Overview of operation
// - Bus bits positive logic, bit zero least.
// - Slave write captured at strobe rising edge.
// - Slave read drives register while strobe low.
// - Slave port needs no bussed clock.
// - Master write data surrounds the strobe pulse.
// - Master read samples at strobe rising edge.
// - Direction high reads, low writes.
// - Direction stable from latch strobe to end.
// - Transmit enable low while sending, high otherwise as master, floats when not master.
// - Receive enable low while taking, high otherwise as master, floats when not master.
// - Address latch strobe active high, never floats.
// - Strobe, direction and buffer enables driven only while controlling system bus.
// - Zero, one, two or four waits per side.
// - Option disables the hardware wait input.
// - Base registers reload addresses and count.
// - Swap command exchanges source and destination.
// - Chain start loads channel registers from memory.
// - Search compares source data with masked pattern.
// - Byte/word packing and unpacking supported.
// - Addresses increment, decrement or hold.
// - Pointer select loads pointer, else data.
// - Chip select ignored while bus master.
// - Bus acknowledge synchronised before use.
package dsb_pkg;
	// Register word indices
	localparam logic [3:0] IDX_MODE = 4'h0;
	localparam logic [3:0] IDX_CMD = 4'h1;
	localparam logic [3:0] IDX_SRC = 4'h2;
	localparam logic [3:0] IDX_DST = 4'h3;
	localparam logic [3:0] IDX_CNT = 4'h4;
	localparam logic [3:0] IDX_BSRC = 4'h5;
	localparam logic [3:0] IDX_BDST = 4'h6;
	localparam logic [3:0] IDX_BCNT = 4'h7;
	localparam logic [3:0] IDX_PAT = 4'h8;
	localparam logic [3:0] IDX_MASK = 4'h9;
	localparam logic [3:0] IDX_CHAIN = 4'hA;
	localparam logic [3:0] IDX_STAT = 4'hB;
	localparam logic [3:0] IDX_PTR = 4'hC;
	localparam int NUM_REGS = 13;
	// Mode register fields
	localparam int MODE_WDIS = 0;
	localparam int MODE_SWAIT = 1;
	localparam int MODE_DWAIT = 3;
	localparam int MODE_SSTEP = 5;
	localparam int MODE_DSTEP = 7;
	localparam int MODE_SBYTE = 9;
	localparam int MODE_DBYTE = 10;
	localparam int MODE_OP = 11;
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Command register bits
	localparam int CMD_START = 0;
	localparam int CMD_SWAP = 1;
	localparam int CMD_RELOAD = 2;
	localparam int CMD_CHAIN = 3;
	localparam int CMD_STOP = 4;
	// Address step and operation codes
	localparam logic [1:0] STEP_INC = 2'h0;
	localparam logic [1:0] STEP_DEC = 2'h1;
	localparam logic [1:0] OP_XFER = 2'h0;
	localparam logic [1:0] OP_SEARCH = 2'h1;
	// Wait state counts per select code
	localparam logic [2:0] WAIT_N0 = 3'h0;
	localparam logic [2:0] WAIT_N1 = 3'h1;
	localparam logic [2:0] WAIT_N2 = 3'h2;
	localparam logic [2:0] WAIT_N4 = 3'h4;
	// Last chain table word index
	localparam logic [1:0] CHAIN_LAST = 2'h3;
	// Master sequencer states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_REQ = 8'h02,
		ST_ALE = 8'h04,
		ST_SETUP = 8'h08,
		ST_STRB = 8'h10,
		ST_WAIT = 8'h20,
		ST_END = 8'h40,
		ST_NEXT = 8'h80
	} dsb_state_t;
endpackage

// [core/dsb_core.sv]
// Purpose: Single-channel DMA engine and muxed system bus interface.
// Assumes: Bus pins are sampled as synchronous to pclk.
// Notes: Two-way pins are split into in, out and output enable.
`timescale 1ns/1ps
`default_nettype none
module dsb_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] muxed_addr_data_bus_in,
	output logic [15:0] muxed_addr_data_bus_out,
	output logic muxed_addr_data_bus_oe,
	input wire logic data_strobe_n_in,
	output logic data_strobe_n_out,
	output logic data_strobe_n_oe,
	input wire logic read_write_in,
	output logic read_write_out,
	output logic read_write_oe,
	output logic addr_latch,
	output logic tx_buffer_enable_n,
	output logic tx_buffer_enable_oe,
	output logic rx_buffer_enable_n,
	output logic rx_buffer_enable_oe,
	input wire logic chip_select_n,
	input wire logic pointer_select,
	input wire logic wait_n,
	output logic bus_request,
	input wire logic bus_ack
);
	////////////////////////////////////////////////////////////////////////
	// Storage
	logic [15:0] mode; // Channel mode
	logic [15:0] src_addr, dst_addr, count; // Current channel state
	logic [15:0] base_src, base_dst, base_cnt; // Reload copies
	logic [15:0] pattern, mask, chain_addr; // Search and chain setup
	logic [15:0] temp; // Data held between read and write
	logic [15:0] rd_latch; // Bus value caught at strobe rise
	logic [3:0] ptr; // Slave register pointer
	logic match_flag, done_flag, stop_req;
	dsb_pkg::dsb_state_t state, next_state;
	logic kind_write, kind_chain, half; // Current bus cycle kind
	logic [1:0] chain_idx;
	logic [2:0] wait_cnt;
	logic ack_s1, ack_s2; // Bus acknowledge synchroniser
	logic ds_q, ds_q2, cs_n_q, cs_n_q2, rw_q, rw_q2, ptr_q2; // Slave samples
	logic ptr_q;
	logic [15:0] bus_q, bus_q2;

	////////////////////////////////////////////////////////////////////////
	// Register view and decode
	logic [15:0] reg_view [0:dsb_pkg::NUM_REGS-1];
	wire logic busy = (state != dsb_pkg::ST_IDLE);
	wire logic mastering = !(state == dsb_pkg::ST_IDLE || state == dsb_pkg::ST_REQ);
	assign reg_view[dsb_pkg::IDX_MODE] = mode;
	assign reg_view[dsb_pkg::IDX_CMD] = 16'h0000; // Commands read back zero
	assign reg_view[dsb_pkg::IDX_SRC] = src_addr;
	assign reg_view[dsb_pkg::IDX_DST] = dst_addr;
	assign reg_view[dsb_pkg::IDX_CNT] = count;
	assign reg_view[dsb_pkg::IDX_BSRC] = base_src;
	assign reg_view[dsb_pkg::IDX_BDST] = base_dst;
	assign reg_view[dsb_pkg::IDX_BCNT] = base_cnt;
	assign reg_view[dsb_pkg::IDX_PAT] = pattern;
	assign reg_view[dsb_pkg::IDX_MASK] = mask;
	assign reg_view[dsb_pkg::IDX_CHAIN] = chain_addr;
	assign reg_view[dsb_pkg::IDX_STAT] = {12'h000, done_flag, match_flag, mastering, busy};
	assign reg_view[dsb_pkg::IDX_PTR] = {12'h000, ptr};

	// APB decode: aligned word inside the map
	wire logic [3:0] apb_idx = paddr[5:2];
	wire logic apb_mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0)
		&& (apb_idx <= dsb_pkg::IDX_PTR);
	wire logic apb_fire = psel && penable && pready;
	wire logic apb_wr = apb_fire && pwrite && apb_mapped;
	wire logic [15:0] apb_rd = apb_mapped ? reg_view[apb_idx] : 16'h0000;

	// Slave port strobe events, chip select ignored as master
	wire logic ptr_mapped = (ptr <= dsb_pkg::IDX_PTR);
	wire logic slv_wr = !mastering && ds_q && !ds_q2 && !cs_n_q2 && !rw_q2;
	wire logic slv_wr_ptr = slv_wr && ptr_q2;
	wire logic slv_wr_reg = slv_wr && !ptr_q2 && ptr_mapped;
	wire logic slv_rd = !mastering && !ds_q && !cs_n_q && rw_q;
	wire logic [15:0] slv_rd_data = ptr_q ? {12'h000, ptr}
		: (ptr_mapped ? reg_view[ptr] : 16'h0000);

	// One write port; APB wins a same-cycle collision
	wire logic wr_en = apb_wr || slv_wr_reg;
	wire logic [3:0] wr_idx = apb_wr ? apb_idx : ptr;
	wire logic [15:0] wr_data = apb_wr ? pwdata[15:0] : bus_q2;
	wire logic cmd_hit = wr_en && (wr_idx == dsb_pkg::IDX_CMD);
	wire logic cmd_start = cmd_hit && wr_data[dsb_pkg::CMD_START];
	wire logic cmd_swap = cmd_hit && wr_data[dsb_pkg::CMD_SWAP] && !busy;
	wire logic cmd_reload = cmd_hit && wr_data[dsb_pkg::CMD_RELOAD] && !busy;
	wire logic cmd_chain = cmd_hit && wr_data[dsb_pkg::CMD_CHAIN];
	wire logic cmd_stop = cmd_hit && wr_data[dsb_pkg::CMD_STOP];

	////////////////////////////////////////////////////////////////////////
	// Channel datapath
	wire logic sbyte = mode[dsb_pkg::MODE_SBYTE];
	wire logic dbyte = mode[dsb_pkg::MODE_DBYTE];
	wire logic [1:0] op = mode[dsb_pkg::MODE_OP+1:dsb_pkg::MODE_OP];
	wire logic pack = sbyte && !dbyte; // Two byte reads make a word
	wire logic unpack = !sbyte && dbyte; // One word read feeds two writes
	wire logic [1:0] wsel = kind_write ? mode[dsb_pkg::MODE_DWAIT+1:dsb_pkg::MODE_DWAIT]
		: mode[dsb_pkg::MODE_SWAIT+1:dsb_pkg::MODE_SWAIT];
	// Programmed wait count for the cycle side
	wire logic [2:0] wait_load = (wsel == 2'h0) ? dsb_pkg::WAIT_N0
		: (wsel == 2'h1) ? dsb_pkg::WAIT_N1
		: (wsel == 2'h2) ? dsb_pkg::WAIT_N2 : dsb_pkg::WAIT_N4;
	wire logic hw_ready = mode[dsb_pkg::MODE_WDIS] || wait_n;
	wire logic strobe_done = (wait_cnt == 3'h0) && hw_ready;
	wire logic [15:0] cur_addr = kind_chain ? chain_addr : (kind_write ? dst_addr : src_addr);
	wire logic cyc_byte = !kind_chain && (kind_write ? dbyte : sbyte);
	// Even address is the upper lane, odd address the lower
	wire logic [7:0] rd_byte = src_addr[0] ? rd_latch[7:0] : rd_latch[15:8];
	wire logic [15:0] datum = !sbyte ? rd_latch
		: (pack ? (half ? {temp[15:8], rd_byte} : {rd_byte, 8'h00}) : {8'h00, rd_byte});
	wire logic src_whole = !kind_write && !kind_chain && !(pack && !half);
	wire logic hit = (((datum ^ pattern) & ~mask) == 16'h0000);
	wire logic searching = (op != dsb_pkg::OP_XFER);
	wire logic [7:0] out_byte = (unpack && !half) ? temp[15:8] : temp[7:0];
	wire logic [15:0] wr_word = dbyte ? {out_byte, out_byte} : temp;

	// Step size and direction for one address
	function automatic logic [15:0] dsb_step(input logic [15:0] a, input logic [1:0] st,
		input logic byt);
		logic [15:0] d;
		d = byt ? 16'h0001 : 16'h0002;
		if (st == dsb_pkg::STEP_INC) begin
			dsb_step = a + d;
		end else if (st == dsb_pkg::STEP_DEC) begin
			dsb_step = a - d;
		end else begin
			dsb_step = a; // Hold
		end
	endfunction

	wire logic at_end = (state == dsb_pkg::ST_END);
	wire logic end_src = at_end && !kind_write && !kind_chain;
	wire logic end_wr = at_end && kind_write;
	wire logic end_chain = at_end && kind_chain;
	// One count unit per destination write, or per datum when only searching
	wire logic cnt_dec = end_wr || (end_src && src_whole && op == dsb_pkg::OP_SEARCH);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		next_state = state;
		unique case (state)
			dsb_pkg::ST_IDLE: begin
				if (cmd_chain || (cmd_start && count != 16'h0000)) begin
					next_state = dsb_pkg::ST_REQ;
				end
			end
			dsb_pkg::ST_REQ: begin
				if (ack_s2) begin
					next_state = dsb_pkg::ST_ALE;
				end
			end
			dsb_pkg::ST_ALE: next_state = dsb_pkg::ST_SETUP;
			dsb_pkg::ST_SETUP: next_state = dsb_pkg::ST_STRB;
			dsb_pkg::ST_STRB, dsb_pkg::ST_WAIT: begin
				next_state = strobe_done ? dsb_pkg::ST_END : dsb_pkg::ST_WAIT;
			end
			dsb_pkg::ST_END: next_state = dsb_pkg::ST_NEXT;
			dsb_pkg::ST_NEXT: begin
				// Stop after the current bus cycle on command, at a datum boundary on match or count out
				if (stop_req || (!kind_write && !kind_chain && !half && count == 16'h0000)) begin
					next_state = dsb_pkg::ST_IDLE;
				end else begin
					next_state = dsb_pkg::ST_ALE;
				end
			end
		endcase
	end

	// Pin values follow the coming state so they leave flip-flops
	wire logic n_drive = !(next_state == dsb_pkg::ST_IDLE || next_state == dsb_pkg::ST_REQ);
	wire logic n_addr = (next_state == dsb_pkg::ST_ALE);
	wire logic n_low = (next_state == dsb_pkg::ST_STRB) || (next_state == dsb_pkg::ST_WAIT);
	wire logic n_data = (next_state == dsb_pkg::ST_SETUP) || n_low
		|| (next_state == dsb_pkg::ST_END);
	wire logic n_mwr = n_drive && n_data && kind_write;
	wire logic next_bus_oe = n_drive ? (n_addr || n_mwr) : slv_rd;
	wire logic [15:0] next_bus_out = !n_drive ? slv_rd_data
		: (n_addr ? cur_addr : wr_word);

	////////////////////////////////////////////////////////////////////////
	// Sequencer state and pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= dsb_pkg::ST_IDLE;
			muxed_addr_data_bus_out <= 16'h0000;
			muxed_addr_data_bus_oe <= 1'b0;
			data_strobe_n_out <= 1'b1;
			data_strobe_n_oe <= 1'b0;
			read_write_out <= 1'b1;
			read_write_oe <= 1'b0;
			addr_latch <= 1'b0;
			tx_buffer_enable_n <= 1'b1;
			tx_buffer_enable_oe <= 1'b0;
			rx_buffer_enable_n <= 1'b1;
			rx_buffer_enable_oe <= 1'b0;
			bus_request <= 1'b0;
		end else begin
			state <= next_state;
			muxed_addr_data_bus_out <= next_bus_out;
			muxed_addr_data_bus_oe <= next_bus_oe;
			data_strobe_n_out <= !n_low;
			data_strobe_n_oe <= n_drive;
			read_write_out <= !kind_write;
			read_write_oe <= n_drive;
			addr_latch <= n_addr;
			tx_buffer_enable_n <= !(n_drive && kind_write && n_data);
			tx_buffer_enable_oe <= n_drive;
			rx_buffer_enable_n <= !(n_drive && !kind_write && n_low);
			rx_buffer_enable_oe <= n_drive;
			bus_request <= (next_state != dsb_pkg::ST_IDLE);
		end
	end

	// Cycle kind, waits and read capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind_write <= 1'b0;
			kind_chain <= 1'b0;
			half <= 1'b0;
			chain_idx <= 2'h0;
			wait_cnt <= 3'h0;
			rd_latch <= 16'h0000;
			temp <= 16'h0000;
		end else begin
			if (state == dsb_pkg::ST_IDLE) begin
				kind_write <= 1'b0;
				kind_chain <= cmd_chain;
				half <= 1'b0;
				chain_idx <= 2'h0;
			end
			if (state == dsb_pkg::ST_SETUP) begin
				wait_cnt <= kind_chain ? dsb_pkg::WAIT_N0 : wait_load;
			end else if (wait_cnt != 3'h0 && (state == dsb_pkg::ST_STRB || state == dsb_pkg::ST_WAIT)) begin
				wait_cnt <= wait_cnt - 3'h1;
			end
			// Data taken on the strobe's rising edge
			if ((state == dsb_pkg::ST_STRB || state == dsb_pkg::ST_WAIT) && strobe_done) begin
				rd_latch <= muxed_addr_data_bus_in;
			end
			if (end_chain) begin
				kind_chain <= (chain_idx != dsb_pkg::CHAIN_LAST);
				chain_idx <= chain_idx + 2'h1;
			end
			if (end_src) begin
				temp <= datum;
				half <= pack && !half;
				kind_write <= src_whole && op != dsb_pkg::OP_SEARCH;
			end
			if (end_wr) begin
				half <= unpack && !half;
				kind_write <= unpack && !half;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software registers; chaining also loads mode and advances the chain address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= dsb_pkg::MODE_RESET;
			base_src <= dsb_pkg::REG_RESET;
			base_dst <= dsb_pkg::REG_RESET;
			base_cnt <= dsb_pkg::REG_RESET;
			pattern <= dsb_pkg::REG_RESET;
			mask <= dsb_pkg::REG_RESET;
			chain_addr <= dsb_pkg::REG_RESET;
			ptr <= 4'h0;
		end else begin
			if (end_chain && chain_idx == dsb_pkg::CHAIN_LAST) begin
				mode <= rd_latch;
			end else if (wr_en && wr_idx == dsb_pkg::IDX_MODE) begin
				mode <= wr_data;
			end
			if (wr_en && wr_idx == dsb_pkg::IDX_BSRC) base_src <= wr_data;
			if (wr_en && wr_idx == dsb_pkg::IDX_BDST) base_dst <= wr_data;
			if (wr_en && wr_idx == dsb_pkg::IDX_BCNT) base_cnt <= wr_data;
			if (wr_en && wr_idx == dsb_pkg::IDX_PAT) pattern <= wr_data;
			if (wr_en && wr_idx == dsb_pkg::IDX_MASK) mask <= wr_data;
			if (end_chain) begin
				chain_addr <= chain_addr + 16'h0002; // Table walks upward
			end else if (wr_en && wr_idx == dsb_pkg::IDX_CHAIN) begin
				chain_addr <= wr_data;
			end
			if (slv_wr_ptr) begin
				ptr <= bus_q2[3:0];
			end else if (apb_wr && apb_idx == dsb_pkg::IDX_PTR) begin
				ptr <= pwdata[3:0];
			end
		end
	end

	// Channel address and count: commands, chain, software, then engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_addr <= dsb_pkg::REG_RESET;
			dst_addr <= dsb_pkg::REG_RESET;
			count <= dsb_pkg::REG_RESET;
		end else if (cmd_swap) begin
			src_addr <= dst_addr;
			dst_addr <= src_addr;
		end else if (cmd_reload) begin
			src_addr <= base_src;
			dst_addr <= base_dst;
			count <= base_cnt;
		end else if (end_chain) begin
			if (chain_idx == 2'h0) src_addr <= rd_latch;
			if (chain_idx == 2'h1) dst_addr <= rd_latch;
			if (chain_idx == 2'h2) count <= rd_latch;
		end else begin
			if (wr_en && wr_idx == dsb_pkg::IDX_SRC) begin
				src_addr <= wr_data;
			end else if (end_src) begin
				src_addr <= dsb_step(src_addr, mode[dsb_pkg::MODE_SSTEP+1:dsb_pkg::MODE_SSTEP],
					cyc_byte);
			end
			if (wr_en && wr_idx == dsb_pkg::IDX_DST) begin
				dst_addr <= wr_data;
			end else if (end_wr) begin
				dst_addr <= dsb_step(dst_addr, mode[dsb_pkg::MODE_DSTEP+1:dsb_pkg::MODE_DSTEP],
					cyc_byte);
			end
			if (wr_en && wr_idx == dsb_pkg::IDX_CNT) begin
				count <= wr_data;
			end else if (cnt_dec && count != 16'h0000) begin
				count <= count - 16'h0001;
			end
		end
	end

	// Flags: hardware set wins over the start clear
	wire logic set_match = end_src && src_whole && searching && hit;
	wire logic set_done = (state == dsb_pkg::ST_NEXT && next_state == dsb_pkg::ST_IDLE)
		|| (state == dsb_pkg::ST_IDLE && cmd_start && count == 16'h0000);
	// Search alone stops at once; transfer-and-search after the write
	wire logic stop_set = cmd_stop || (set_match && op == dsb_pkg::OP_SEARCH)
		|| (end_wr && match_flag && searching && !(unpack && !half));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_flag <= 1'b0;
			done_flag <= 1'b0;
			stop_req <= 1'b0;
		end else begin
			match_flag <= set_match || (match_flag && !cmd_start && !cmd_chain);
			done_flag <= set_done || (done_flag && !cmd_start && !cmd_chain);
			stop_req <= busy && (stop_set || (stop_req && state != dsb_pkg::ST_NEXT));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sampling; the acknowledge gets a two-stage synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ds_q <= 1'b1;
			ds_q2 <= 1'b1;
			cs_n_q <= 1'b1;
			cs_n_q2 <= 1'b1;
			rw_q <= 1'b1;
			rw_q2 <= 1'b1;
			ptr_q <= 1'b0;
			ptr_q2 <= 1'b0;
			bus_q <= 16'h0000;
			bus_q2 <= 16'h0000;
		end else begin
			ack_s1 <= bus_ack;
			ack_s2 <= ack_s1;
			ds_q <= data_strobe_n_in;
			ds_q2 <= ds_q;
			cs_n_q <= chip_select_n;
			cs_n_q2 <= cs_n_q;
			rw_q <= read_write_in;
			rw_q2 <= rw_q;
			ptr_q <= pointer_select;
			ptr_q2 <= ptr_q;
			bus_q <= muxed_addr_data_bus_in;
			bus_q2 <= bus_q;
		end
	end

	// APB slave: one wait cycle, error on unmapped words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !apb_mapped;
			if (psel && penable && !pready) begin
				prdata <= {16'h0000, apb_rd};
			end
		end
	end
endmodule
`default_nettype wire

// [bench/dsb_core_chk.sv]
// Purpose: Port-level assertions on the DMA system bus interface.
// Assumes: One clock pclk, reset presetn active low.
// Notes: Bound into every dsb_core instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module dsb_core_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] muxed_addr_data_bus_out,
	input wire logic muxed_addr_data_bus_oe,
	input wire logic data_strobe_n_out,
	input wire logic data_strobe_n_oe,
	input wire logic read_write_out,
	input wire logic read_write_oe,
	input wire logic addr_latch,
	input wire logic tx_buffer_enable_n,
	input wire logic tx_buffer_enable_oe,
	input wire logic rx_buffer_enable_n,
	input wire logic rx_buffer_enable_oe,
	input wire logic bus_request
);
	// Everything on the bus clock, quiet in reset
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Master write: our own direction line says write
	wire logic mwr = read_write_oe && !read_write_out;
	////////////////////////////////////////////////////////////////////////
	ale_drives_a: assert property (addr_latch
		|-> muxed_addr_data_bus_oe && read_write_oe)
		else $error("latch strobe without address drive");
	ale_pulse_a: assert property (addr_latch |=> !addr_latch)
		else $error("latch strobe longer than one cycle");
	rw_stable_a: assert property (addr_latch |=> ($stable(read_write_out)) [*3])
		else $error("direction moved inside bus cycle");
	wr_setup_a: assert property ($fell(data_strobe_n_out) && mwr
		|-> muxed_addr_data_bus_oe && $stable(muxed_addr_data_bus_out))
		else $error("write data not set up before strobe");
	wr_hold_a: assert property ($rose(data_strobe_n_out) && mwr
		|-> muxed_addr_data_bus_oe && $stable(muxed_addr_data_bus_out))
		else $error("write data not held past strobe");
	tx_low_a: assert property (tx_buffer_enable_oe && !tx_buffer_enable_n
		|-> muxed_addr_data_bus_oe && mwr)
		else $error("transmit enable outside a write");
	rx_low_a: assert property (rx_buffer_enable_oe && !rx_buffer_enable_n
		|-> !muxed_addr_data_bus_oe && read_write_out)
		else $error("receive enable outside a read");
	slave_float_a: assert property (!bus_request [*3]
		|-> !data_strobe_n_oe && !tx_buffer_enable_oe && !rx_buffer_enable_oe)
		else $error("pins driven while not master");
	// Main scenarios reached
	cover property (addr_latch);
	cover property ($fell(data_strobe_n_out) && read_write_out);
	cover property (tx_buffer_enable_oe && !tx_buffer_enable_n);
endmodule
bind dsb_core dsb_core_chk u_dsb_core_chk (.*);
`default_nettype wire

// [bench/dsb_mem.sv]
// Purpose: Word memory on the muxed bus, answering the engine as master.
// Assumes: Word transfers, address bits 4:1 pick the word.
// Notes: Slow mode pulls the wait line for two cycles per strobe.
`timescale 1ns/1ps
`default_nettype none
module dsb_mem (
	input wire logic pclk,
	input wire logic addr_latch,
	input wire logic [15:0] bus,
	input wire logic strobe_n,
	input wire logic rw,
	input wire logic slow,
	output logic [15:0] rdata,
	output logic drive,
	output logic wait_n
);
	logic [15:0] mem [16]; // Word store
	logic [3:0] addr; // Latched word address
	logic sel = 1'b0; // Selected by a latch strobe
	logic strobe_q = 1'b1; // Strobe one clock back
	logic [1:0] wcnt = 2'h0; // Waits issued this strobe
	initial for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
	// Latch address, store on strobe rise; outside masters never select us
	always @(posedge pclk) begin
		strobe_q <= strobe_n;
		if (addr_latch) begin
			addr <= bus[4:1];
			sel <= 1'b1;
		end else if (strobe_n && !strobe_q) begin
			sel <= 1'b0;
			if (sel && !rw) mem[addr] <= bus;
		end
		wcnt <= strobe_n ? 2'h0 : (wcnt == 2'h2 ? wcnt : wcnt + 2'h1);
	end
	// Data valid for the whole strobe so the rising edge catches it
	assign drive = sel && !strobe_n && rw;
	assign rdata = mem[addr];
	assign wait_n = !(slow && !strobe_n && wcnt != 2'h2);
endmodule
`default_nettype wire

// [bench/dsb_core_tb.sv]
// Purpose: Self-checking bench for the DMA system bus interface.
// Assumes: APB at 25 MHz, memory model on the muxed bus.
// Notes: Register cases run from a table, bus cases by hand.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module dsb_core_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, bus_request, bus_ack = 1'b0, wait_n, slow = 1'b0;
	logic [15:0] muxed_addr_data_bus_out, mdat, tdat = 16'h0000, bq = 16'h0000, q;
	logic muxed_addr_data_bus_oe, moe, toe = 1'b0, dsi = 1'b1, rwi = 1'b1;
	logic data_strobe_n_out, data_strobe_n_oe, read_write_out, read_write_oe, addr_latch;
	logic chip_select_n = 1'b1, pointer_select = 1'b0;
	logic tx_buffer_enable_n, tx_buffer_enable_oe, rx_buffer_enable_n, rx_buffer_enable_oe;
	wire logic [15:0] muxed_addr_data_bus_in;
	wire logic data_strobe_n_in, read_write_in;
	int n_mismatch = 0, n_tests = 0, low_run = 0, low_max = 0;
	int wl [4] = '{0, 1, 2, 4}; // Waits per select code
	logic [40:0] rows [11]; // Address, write data, read back, error
	////////////////////////////////////////////////////////////////////////
	// Pin levels: released bus shows the inverse of its last value
	assign data_strobe_n_in = data_strobe_n_oe ? data_strobe_n_out : dsi;
	assign read_write_in = read_write_oe ? read_write_out : rwi;
	assign muxed_addr_data_bus_in = muxed_addr_data_bus_oe ? muxed_addr_data_bus_out :
		moe ? mdat : toe ? tdat : ~bq;
	dsb_core u_dsb_core (.*);
	dsb_mem u_dsb_mem (.pclk, .addr_latch, .bus(muxed_addr_data_bus_in),
		.strobe_n(data_strobe_n_in), .rw(read_write_in), .slow, .rdata(mdat), .drive(moe),
		.wait_n);
	initial forever #20 pclk = ~pclk;
	// Grant the bus at once, time each master strobe pulse
	always @(posedge pclk) begin
		bq <= muxed_addr_data_bus_in;
		bus_ack <= bus_request;
		if (data_strobe_n_oe && !data_strobe_n_out) begin
			low_run <= low_run + 1;
			if (low_run + 1 > low_max) low_max <= low_run + 1;
		end else low_run <= 0;
	end
	////////////////////////////////////////////////////////////////////////
	// One APB transfer; holds the request until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Command, then poll status until done
	task automatic run(input logic [15:0] cmd);
		apb(1'b1, 8'h04, cmd);
		do apb(1'b0, 8'h2C, 16'h0000); while (r[3] !== 1'b1);
	endtask
	// Outside master on the muxed port; strobe held low four cycles
	task automatic sp(input logic p, input logic rd, input logic [15:0] d);
		@(posedge pclk);
		chip_select_n <= 1'b0;
		pointer_select <= p;
		rwi <= rd;
		tdat <= d;
		toe <= !rd;
		dsi <= 1'b0;
		repeat (4) @(posedge pclk);
		q = muxed_addr_data_bus_in;
		dsi <= 1'b1;
		@(posedge pclk);
		chip_select_n <= 1'b1;
		toe <= 1'b0;
		@(posedge pclk);
	endtask
	task report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#2000000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		rows = '{{8'h08, 16'h1234, 16'h1234, 1'b0}, {8'h0C, 16'hABCD, 16'hABCD, 1'b0},
			{8'h14, 16'h0102, 16'h0102, 1'b0}, {8'h20, 16'h5A5A, 16'h5A5A, 1'b0},
			{8'h24, 16'h00FF, 16'h00FF, 1'b0}, {8'h28, 16'hC3C3, 16'hC3C3, 1'b0},
			{8'h30, 16'h0007, 16'h0007, 1'b0}, {8'h04, 16'h0000, 16'h0000, 1'b0},
			{8'h2C, 16'hFFFF, 16'h0000, 1'b0}, {8'h34, 16'hFFFF, 16'h0000, 1'b1},
			{8'h40, 16'hFFFF, 16'h0000, 1'b1}};
		repeat (4) @(posedge pclk);
		`CHK({data_strobe_n_oe, read_write_oe, tx_buffer_enable_oe, rx_buffer_enable_oe,
			muxed_addr_data_bus_oe, addr_latch, bus_request}, 7'h00)
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i][40:33], rows[i][32:17]);
			apb(1'b0, rows[i][40:33], 16'h0000);
			`CHK(r, {16'h0000, rows[i][16:1]})
			`CHK(e, rows[i][0])
		end
		$display("register table done");
		apb(1'b1, 8'h08, 16'h0002);
		apb(1'b1, 8'h0C, 16'h0010);
		apb(1'b1, 8'h04, 16'h0002);
		apb(1'b0, 8'h08, 16'h0000);
		`CHK(r[15:0], 16'h0010)
		apb(1'b0, 8'h0C, 16'h0000);
		`CHK(r[15:0], 16'h0002)
		apb(1'b1, 8'h14, 16'h0030);
		apb(1'b1, 8'h04, 16'h0004);
		apb(1'b0, 8'h08, 16'h0000);
		`CHK(r[15:0], 16'h0030)
		$display("swap and reload done");
		// Memory stalls throughout; the wait line is disabled except in the last run
		slow <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, 16'h0001 | 16'(i << 1) | 16'(i << 3));
			apb(1'b1, 8'h08, 16'h0000);
			apb(1'b1, 8'h0C, 16'(16'h0010 + 2 * i));
			apb(1'b1, 8'h10, 16'h0001);
			low_max = 0;
			run(16'h0001);
			`CHK(low_max, 1 + wl[i])
			`CHK(u_dsb_mem.mem[8 + i], 16'h1000)
			`CHK(r[3:0], 4'h8)
		end
		apb(1'b1, 8'h00, 16'h0000);
		apb(1'b1, 8'h10, 16'h0001);
		low_max = 0;
		run(16'h0001);
		`CHK(low_max > 1, 1'b1)
		$display("wait states done");
		apb(1'b1, 8'h00, 16'h0801);
		apb(1'b1, 8'h08, 16'h0000);
		apb(1'b1, 8'h20, 16'h1103);
		apb(1'b1, 8'h24, 16'h0100);
		apb(1'b1, 8'h10, 16'h0008);
		run(16'h0001);
		`CHK(r[2], 1'b1)
		apb(1'b1, 8'h00, 16'h0201);
		apb(1'b1, 8'h08, 16'h0001);
		apb(1'b1, 8'h10, 16'h0001);
		run(16'h0001);
		`CHK(u_dsb_mem.mem[13], 16'h0010)
		$display("search and pack done");
		sp(1'b1, 1'b0, 16'h0003);
		sp(1'b0, 1'b0, 16'h5AA5);
		apb(1'b0, 8'h0C, 16'h0000);
		`CHK(r[15:0], 16'h5AA5)
		sp(1'b0, 1'b1, 16'h0000);
		`CHK(q, 16'h5AA5)
		sp(1'b1, 1'b1, 16'h0000);
		`CHK(q, 16'h0003)
		$display("slave port done");
		report_and_stop();
	end
endmodule
`default_nettype wire
